// >>> hw/pnm_regs.svh
`ifndef PNM_REGS_SVH
`define PNM_REGS_SVH
`define PNM_STRAP_MII       3'h0
`define PNM_STRAP_RMII      3'h1
`define PNM_CLK_HZ          10000000
`define PNM_JABBER_MS       20
`define PNM_UNJAB_MS        250
`define PNM_JABBER_CYC      ((`PNM_CLK_HZ / 1000) * `PNM_JABBER_MS)
`define PNM_UNJAB_CYC       ((`PNM_CLK_HZ / 1000) * `PNM_UNJAB_MS)
`define PNM_SQE_CYC         8
`define PNM_HALF_10M        2
`define PNM_SFD_LO          4'h5
`define PNM_SFD_HI          4'hd
`define PNM_PRE_NIB         4'h5
`endif

// >>> hw/pnm_pkg.sv
package pnm_pkg;
  typedef enum logic [1:0] {
    PNM_MODE_MII  = 2'b01,
    PNM_MODE_RMII = 2'b10
  } pnm_mode_t;
  typedef enum logic [3:0] {
    PNM_RX_IDLE = 4'b0001,
    PNM_RX_PRE  = 4'b0010,
    PNM_RX_DATA = 4'b0100,
    PNM_RX_END  = 4'b1000
  } pnm_rx_state_t;
endpackage

// >>> hw/pnm_sync.sv
`timescale 1ns/1ps
module pnm_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule

// >>> hw/pnm_mac_if.sv
`timescale 1ns/1ps
`include "pnm_regs.svh"
// Functional notes
// RULE_01 - Strap 000 selects nibble mode
// RULE_02 - Strap 001 selects two-bit reduced mode
// RULE_03 - Generating variant drives reduced reference clock out
// RULE_04 - Controller ties upper transmit bits low
// RULE_05 - Source continuous transmit and receive clocks
// RULE_06 - Slow rate: line clock only with carrier
// RULE_07 - Fast rate: line clock unless link down
// RULE_08 - Controller frames transmit enable with nibbles
// RULE_09 - Transmit data taken only while enabled
// RULE_10 - Slow rate: valid from delimiter nibble
// RULE_11 - Fast rate: valid from preamble start
// RULE_12 - One nibble per valid receive period
// RULE_13 - Flag coding errors in current frame
// RULE_14 - Controller ignores error without valid
// RULE_15 - Slow rate carrier from preamble to end
// RULE_16 - Fast rate carrier from start to end pair
// RULE_17 - Idle without end pair drops carrier
// RULE_18 - Half duplex collision on simultaneous activity
// RULE_19 - Slow rate collision test pulse after frame
// RULE_20 - Jabber disables transmitter, holds collision
// RULE_21 - Receive clock switches source without glitches
module pnm_mac_if #(
  parameter int          JABBER_CYC = `PNM_JABBER_CYC,
  parameter int          UNJAB_CYC  = `PNM_UNJAB_CYC,
  parameter logic        GEN_REDUCED_MODE_CLOCK_IN = 1'b0
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] mode_strap_i,
  input  wire logic       speed_100_i,
  input  wire logic       full_duplex_i,
  input  wire logic       link_up_i,
  input  wire logic       line_clk_i,
  input  wire logic       line_carrier_i,
  input  wire logic       line_sos_i,
  input  wire logic       line_eos_i,
  input  wire logic       line_idle_i,
  input  wire logic [3:0] line_nibble_i,
  input  wire logic       line_code_err_i,
  input  wire logic       transmit_enable_in,
  input  wire logic [3:0] tx_data_i,
  output logic            transmit_clock_out,
  output logic            receive_clock_out,
  output logic            receive_data_valid,
  output logic [3:0]      rx_data_o,
  output logic            receive_error,
  output logic            carrier_sense,
  output logic            collision_o,
  output logic            rmii_mode_o,
  output logic            ref_clk_out_o,
  output logic            ref_clk_oe_o,
  output logic            tx_active_o,
  output logic [3:0]      tx_nibble_o,
  output logic            tx_nibble_vld_o
);
  logic [12:0] sy;
  pnm_sync #(.W(13)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({mode_strap_i, speed_100_i, full_duplex_i, link_up_i, line_clk_i,
                 line_carrier_i, line_sos_i, line_eos_i, line_idle_i,
                 transmit_enable_in, line_code_err_i}),
    .q_o       (sy)
  );
  logic [3:0] rxn_s;
  logic [3:0] txd_s;
  pnm_sync #(.W(8)) u_sync_d (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({line_nibble_i, tx_data_i}),
    .q_o       ({rxn_s, txd_s})
  );
  logic [2:0] strap_s;
  logic       spd_s, fdx_s, lnk_s, lclk_s, car_s, sos_s, eos_s, idl_s, ten_s, err_s;
  assign {strap_s, spd_s, fdx_s, lnk_s, lclk_s, car_s, sos_s, eos_s, idl_s, ten_s, err_s} = sy;

  // Strap capture once the synchroniser holds the strap
  logic [1:0]          wait_q, wait_d;
  logic                latched_q, latched_d;
  pnm_pkg::pnm_mode_t  mode_q, mode_d;
  always_comb begin
    wait_d    = wait_q;
    latched_d = latched_q;
    mode_d    = mode_q;
    if (wait_q != 2'h2) begin
      wait_d = wait_q + 2'h1;
    end else if (!latched_q) begin
      latched_d = 1'b1;
      if (strap_s == `PNM_STRAP_RMII) begin
        mode_d = pnm_pkg::PNM_MODE_RMII; // RULE_02
      end else begin
        mode_d = pnm_pkg::PNM_MODE_MII; // RULE_01
      end
    end
  end

  // Local reference divider: toggle each cycle fast, every HALF_10M slow
  logic       loc_clk_q, loc_clk_d;
  logic [3:0] div_q, div_d;
  logic       ref_q, ref_d;
  always_comb begin
    div_d     = div_q + 4'h1;
    loc_clk_d = loc_clk_q;
    ref_d     = ~ref_q;
    if (spd_s || div_q >= 4'(`PNM_HALF_10M - 1)) begin
      div_d     = 4'h0;
      loc_clk_d = ~loc_clk_q;
    end
  end

  // Receive clock source select, switched only while both sources low
  logic line_ok, use_line_q, use_line_d, rxc_q, rxc_d, rxc_rise;
  assign line_ok = lnk_s && (spd_s || car_s); // RULE_06 RULE_07
  always_comb begin
    use_line_d = use_line_q;
    if (!lclk_s && !loc_clk_q && !rxc_q) begin
      use_line_d = line_ok; // RULE_21
    end
    rxc_d = use_line_q ? lclk_s : loc_clk_q;
  end
  assign rxc_rise = rxc_d && !rxc_q;

  // Receive path, advanced on each receive clock rising edge
  pnm_pkg::pnm_rx_state_t st_q, st_d;
  logic       dv_q, dv_d, crs_q, crs_d, er_q, er_d, prev_hi_q, prev_hi_d;
  logic [3:0] rxd_q, rxd_d;
  always_comb begin
    st_d      = st_q;
    dv_d      = dv_q;
    crs_d     = crs_q;
    er_d      = er_q;
    rxd_d     = rxd_q;
    prev_hi_d = prev_hi_q;
    if (rxc_rise) begin
      prev_hi_d = (rxn_s == `PNM_SFD_LO);
      unique case (st_q)
        pnm_pkg::PNM_RX_IDLE: begin
          if (spd_s ? sos_s : (car_s && rxn_s == `PNM_PRE_NIB)) begin
            crs_d = 1'b1; // RULE_15 RULE_16
            st_d  = pnm_pkg::PNM_RX_PRE;
            if (spd_s) begin
              dv_d = 1'b1; // RULE_11
            end
          end
        end
        pnm_pkg::PNM_RX_PRE: begin
          if (!spd_s && rxn_s == `PNM_SFD_HI && prev_hi_q) begin
            dv_d = 1'b1; // RULE_10
          end
          if (dv_d) begin
            st_d = pnm_pkg::PNM_RX_DATA;
          end
        end
        pnm_pkg::PNM_RX_DATA: begin
          if (spd_s ? (eos_s || idl_s) : !car_s) begin
            st_d = pnm_pkg::PNM_RX_END;
          end
        end
        pnm_pkg::PNM_RX_END: begin
          st_d = pnm_pkg::PNM_RX_IDLE;
        end
      endcase
      if (st_d == pnm_pkg::PNM_RX_END) begin
        crs_d = 1'b0; // RULE_15 RULE_16 RULE_17
        dv_d  = 1'b0;
      end
      if (!lnk_s) begin
        st_d  = pnm_pkg::PNM_RX_IDLE;
        crs_d = 1'b0;
        dv_d  = 1'b0;
      end
      rxd_d = dv_d ? rxn_s : 4'h0; // RULE_12
      er_d  = dv_d && err_s; // RULE_13
    end
  end

  // Jabber state, read by the transmit path
  logic       jab_q, jab_d;

  // Transmit clock and sampling
  logic       txc_q, txc_d, tvld_q, tvld_d, tact_q, tact_d, txc_rise, tx_take;
  logic [3:0] tnib_q, tnib_d;
  assign txc_rise = loc_clk_q && !txc_q;
  assign tx_take  = txc_rise && ten_s && !jab_q; // RULE_09
  always_comb begin
    txc_d  = loc_clk_q; // RULE_05
    tvld_d = 1'b0;
    tnib_d = tnib_q;
    tact_d = tact_q;
    if (txc_rise) begin
      tact_d = ten_s;
    end
    if (tx_take) begin
      tvld_d = 1'b1;
      tnib_d = txd_s; // RULE_09
      if (mode_q == pnm_pkg::PNM_MODE_RMII) begin
        tnib_d = {2'b00, txd_s[1:0]}; // RULE_04
      end
    end
  end

  // Jabber and collision test pulse
  logic [31:0] jcnt_q, jcnt_d;
  logic [3:0]  sqe_q, sqe_d;
  logic        ten_d1_q;
  always_comb begin
    jab_d  = jab_q;
    jcnt_d = jcnt_q;
    sqe_d  = (sqe_q != 4'h0) ? sqe_q - 4'h1 : 4'h0;
    if (spd_s) begin
      jab_d  = 1'b0;
      jcnt_d = '0;
    end else if (!jab_q) begin
      jcnt_d = ten_s ? jcnt_q + 32'h1 : '0;
      if (jcnt_q >= 32'(JABBER_CYC)) begin
        jab_d  = 1'b1; // RULE_20
        jcnt_d = '0;
      end
    end else begin
      jcnt_d = ten_s ? '0 : jcnt_q + 32'h1;
      if (jcnt_q >= 32'(UNJAB_CYC)) begin
        jab_d  = 1'b0; // RULE_20
        jcnt_d = '0;
      end
    end
    if (!spd_s && ten_d1_q && !ten_s && !jab_q) begin
      sqe_d = 4'(`PNM_SQE_CYC); // RULE_19
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q     <= 2'h0;
      latched_q  <= 1'b0;
      mode_q     <= pnm_pkg::PNM_MODE_MII;
      loc_clk_q  <= 1'b0;
      div_q      <= 4'h0;
      ref_q      <= 1'b0;
      use_line_q <= 1'b0;
      rxc_q      <= 1'b0;
      st_q       <= pnm_pkg::PNM_RX_IDLE;
      dv_q       <= 1'b0;
      crs_q      <= 1'b0;
      er_q       <= 1'b0;
      rxd_q      <= 4'h0;
      prev_hi_q  <= 1'b0;
      txc_q      <= 1'b0;
      tvld_q     <= 1'b0;
      tnib_q     <= 4'h0;
      tact_q     <= 1'b0;
      jab_q      <= 1'b0;
      jcnt_q     <= '0;
      sqe_q      <= 4'h0;
      ten_d1_q   <= 1'b0;
    end else begin
      wait_q     <= wait_d;
      latched_q  <= latched_d;
      mode_q     <= mode_d;
      loc_clk_q  <= loc_clk_d;
      div_q      <= div_d;
      ref_q      <= ref_d;
      use_line_q <= use_line_d;
      rxc_q      <= rxc_d;
      st_q       <= st_d;
      dv_q       <= dv_d;
      crs_q      <= crs_d;
      er_q       <= er_d;
      rxd_q      <= rxd_d;
      prev_hi_q  <= prev_hi_d;
      txc_q      <= txc_d;
      tvld_q     <= tvld_d;
      tnib_q     <= tnib_d;
      tact_q     <= tact_d;
      jab_q      <= jab_d;
      jcnt_q     <= jcnt_d;
      sqe_q      <= sqe_d;
      ten_d1_q   <= ten_s;
    end
  end

  assign transmit_clock_out = txc_q;
  assign receive_clock_out  = rxc_q;
  assign receive_data_valid = dv_q;
  assign rx_data_o          = rxd_q;
  assign receive_error      = er_q;
  assign carrier_sense      = crs_q;
  assign rmii_mode_o        = (mode_q == pnm_pkg::PNM_MODE_RMII);
  logic col_half;
  assign col_half           = !fdx_s && tact_q && crs_q; // RULE_18
  assign collision_o        = jab_q || (sqe_q != 4'h0) || col_half; // RULE_18 RULE_19 RULE_20
  assign ref_clk_oe_o       = GEN_REDUCED_MODE_CLOCK_IN && rmii_mode_o; // RULE_03
  assign ref_clk_out_o      = ref_clk_oe_o && ref_q;
  assign tx_active_o        = tact_q && !jab_q;
  assign tx_nibble_o        = tnib_q;
  assign tx_nibble_vld_o    = tvld_q;
endmodule

// >>> testbench/pnm_mac_if_chk.sv
`timescale 1ns/1ps
module pnm_mac_if_chk #(
  parameter int JABBER_CYC = 50
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic [2:0] mode_strap_i,
  input wire logic       speed_100_i,
  input wire logic       full_duplex_i,
  input wire logic       transmit_enable_in,
  input wire logic       transmit_clock_out,
  input wire logic       receive_data_valid,
  input wire logic [3:0] rx_data_o,
  input wire logic       receive_error,
  input wire logic       carrier_sense,
  input wire logic       collision_o,
  input wire logic       rmii_mode_o,
  input wire logic       tx_active_o,
  input wire logic [3:0] tx_nibble_o,
  input wire logic       tx_nibble_vld_o
);
  logic [3:0]  up_q, up_d;
  logic [15:0] en_q, en_d;
  always_comb begin
    up_d = (up_q == 4'hf) ? up_q : up_q + 4'h1;
    en_d = (transmit_enable_in && !speed_100_i) ? en_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_q <= 4'h0;
      en_q <= 16'h0000;
    end else begin
      up_q <= up_d;
      en_q <= en_d;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_mode_strap: assert property (
    up_q == 4'h6 |-> rmii_mode_o == (mode_strap_i == 3'h1)) else $error("mode mismatch");
  a_rx_idle_zero: assert property (
    !receive_data_valid |-> rx_data_o == 4'h0) else $error("data without valid");
  a_err_in_frame: assert property (
    receive_error |-> receive_data_valid) else $error("error outside frame");
  a_vld_pulse: assert property (
    tx_nibble_vld_o |=> !tx_nibble_vld_o) else $error("nibble strobe too long");
  a_fast_txclk: assert property (
    (up_q == 4'hf && speed_100_i) [*6] |-> $changed(transmit_clock_out))
    else $error("fast transmit clock stalled");
  a_slow_txclk: assert property (
    (up_q == 4'hf && !speed_100_i) [*4] ##0 $rose(transmit_clock_out) |=> transmit_clock_out)
    else $error("slow transmit clock too short");
  a_upper_zero: assert property (
    rmii_mode_o && tx_nibble_vld_o |-> tx_nibble_o[3:2] == 2'h0) else $error("upper bits set");
  a_jabber_col: assert property (
    en_q > JABBER_CYC + 6 |-> collision_o) else $error("jabber not flagged");
  a_half_col: assert property (
    (!full_duplex_i) [*3] ##0 (tx_active_o && carrier_sense) |-> collision_o)
    else $error("collision missed");
  a_test_pulse: assert property (
    (!speed_100_i) [*3] ##0 $fell(transmit_enable_in) |-> ##[1:12] collision_o)
    else $error("test pulse missing");
  c_rx_err: cover property (receive_data_valid && receive_error);
  c_rmii_tx: cover property (tx_nibble_vld_o && rmii_mode_o);
  c_crs_end: cover property ($fell(carrier_sense));
endmodule
bind pnm_mac_if pnm_mac_if_chk #(.JABBER_CYC(JABBER_CYC)) u_chk (.*);

// >>> testbench/pnm_mac_model.sv
`timescale 1ns/1ps
module pnm_mac_model (
  input  wire logic       sys_clk_i,
  input  wire logic       transmit_clock_out,
  input  wire logic       rmii_mode_o,
  output logic            tx_en_o,
  output logic [3:0]      tx_data_o
);
  logic [3:0] sent[$];
  initial begin
    tx_en_o = 1'b0;
    tx_data_o = 4'h0;
  end
  task automatic tick();
    @(posedge transmit_clock_out);
    @(negedge sys_clk_i);
  endtask
  task automatic send(input int n, input logic [3:0] idle);
    logic [3:0] d;
    for (int i = 0; i < n; i++) begin
      tick();
      d = 4'(i * 7 + 5);
      if (rmii_mode_o) d[3:2] = 2'h0;
      tx_en_o = 1'b1;
      tx_data_o = d;
      sent.push_back(d);
    end
    tick();
    tx_en_o = 1'b0;
    tx_data_o = idle;
  endtask
  task automatic jab(input int n);
    tick();
    tx_en_o = 1'b1;
    tx_data_o = 4'h6;
    repeat (n) @(negedge sys_clk_i);
    tx_en_o = 1'b0;
    tx_data_o = 4'h0;
  endtask
endmodule

// >>> testbench/pnm_mac_if_tb.sv
`timescale 1ns/1ps
module pnm_mac_if_tb;
  localparam int JAB = 50;
  localparam int UNJ = 100;
  logic       sys_clk_i, rst_n_i, speed_100_i, full_duplex_i, link_up_i, line_clk_i;
  logic       line_carrier_i, line_sos_i, line_eos_i, line_idle_i, line_code_err_i;
  logic       transmit_enable_in, transmit_clock_out, receive_clock_out, receive_data_valid;
  logic       receive_error, carrier_sense, collision_o, rmii_mode_o, ref_clk_out_o;
  logic       ref_clk_oe_o, tx_active_o, tx_nibble_vld_o;
  logic [2:0] mode_strap_i;
  logic [3:0] line_nibble_i, tx_data_i, rx_data_o, tx_nibble_o;
  logic [3:0] got[$];
  int         n_errors, samples_checked, n_col, n_rxc;
  pnm_mac_if #(.JABBER_CYC(JAB), .UNJAB_CYC(UNJ)) dut (.*);
  pnm_mac_model mac (.sys_clk_i(sys_clk_i), .transmit_clock_out(transmit_clock_out),
    .rmii_mode_o(rmii_mode_o), .tx_en_o(transmit_enable_in), .tx_data_o(tx_data_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #33;
    forever #400 line_clk_i = (line_carrier_i || (speed_100_i && link_up_i)) ? ~line_clk_i : 1'b0;
  end
  always @(negedge sys_clk_i) begin
    if (tx_nibble_vld_o === 1'b1) got.push_back(tx_nibble_o);
    if (collision_o === 1'b1) n_col++;
  end
  always @(posedge receive_clock_out) n_rxc++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    print_verdict();
  end
  task automatic do_reset(input logic [2:0] s);
    rst_n_i = 1'b0;
    mode_strap_i = s;
    repeat (3) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
  endtask
  task automatic line(input logic [3:0] sig, input logic [3:0] nb, input int n);
    {line_carrier_i, line_sos_i, line_eos_i, line_idle_i} = sig;
    line_nibble_i = nb;
    repeat (n * 8) @(negedge sys_clk_i);
  endtask
  task automatic cmp_tx(input int n);
    repeat (40) @(negedge sys_clk_i);
    check(16'(got.size()), 16'(n));
    foreach (got[k]) check(16'(got[k]), 16'(mac.sent[k]));
    got.delete();
    mac.sent.delete();
  endtask
  task automatic t_modes();
    do_reset(3'h1);
    check(16'(rmii_mode_o), 16'h0001);
    check(16'({ref_clk_oe_o, ref_clk_out_o}), 16'h0000);
    speed_100_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    mac.send(4, 4'h0);
    cmp_tx(4);
    do_reset(3'h0);
    check(16'(rmii_mode_o), 16'h0000);
  endtask
  task automatic t_tx(input logic sp);
    speed_100_i = sp;
    full_duplex_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    n_col = 0;
    mac.send(6, 4'ha);
    cmp_tx(6);
    check(16'(n_col), sp ? 16'h0000 : 16'h0008);
  endtask
  task automatic t_jab();
    mac.jab(JAB + 20);
    check(16'(collision_o), 16'h0001);
    repeat (UNJ - 20) @(negedge sys_clk_i);
    check(16'(collision_o), 16'h0001);
    repeat (40) @(negedge sys_clk_i);
    check(16'(collision_o), 16'h0000);
    got.delete();
    t_tx(1'b0);
  endtask
  task automatic t_rx_fast();
    speed_100_i = 1'b1;
    full_duplex_i = 1'b0;
    link_up_i = 1'b1;
    line(4'b1100, 4'h5, 3);
    check(16'({carrier_sense, receive_data_valid}), 16'h0003);
    line(4'b1000, 4'hc, 2);
    check(16'(rx_data_o), 16'h000c);
    n_col = 0;
    mac.send(3, 4'h0);
    check(16'(n_col > 0), 16'h0001);
    line_code_err_i = 1'b1;
    line(4'b1000, 4'hc, 2);
    check(16'(receive_error), 16'h0001);
    line_code_err_i = 1'b0;
    line(4'b1010, 4'hc, 2);
    check(16'({carrier_sense, receive_data_valid}), 16'h0000);
    line(4'b1100, 4'h5, 2);
    line(4'b1001, 4'h0, 2);
    check(16'(carrier_sense), 16'h0000);
    got.delete();
    mac.sent.delete();
  endtask
  task automatic t_rx_slow();
    speed_100_i = 1'b0;
    full_duplex_i = 1'b1;
    line(4'b0000, 4'h0, 2);
    line(4'b1000, 4'h5, 3);
    check(16'({carrier_sense, receive_data_valid}), 16'h0002);
    line(4'b1000, 4'hd, 1);
    line(4'b1000, 4'h3, 2);
    check(16'({receive_data_valid, rx_data_o}), 16'h0013);
    n_rxc = 0;
    line(4'b0000, 4'h0, 4);
    check(16'({carrier_sense, receive_data_valid}), 16'h0000);
    check(16'(n_rxc > 0), 16'h0001);
    line_code_err_i = 1'b1;
    line(4'b0000, 4'h0, 1);
    check(16'(receive_error && receive_data_valid), 16'h0000);
    line_code_err_i = 1'b0;
  endtask
  initial begin
    {speed_100_i, full_duplex_i, link_up_i, line_clk_i, line_carrier_i} = '0;
    {line_sos_i, line_eos_i, line_idle_i, line_code_err_i} = '0;
    line_nibble_i = 4'h0;
    t_modes();
    t_tx(1'b1);
    t_tx(1'b0);
    t_jab();
    t_rx_fast();
    t_rx_slow();
    print_verdict();
  end
endmodule
